// ===== src/two_channel_timer_pwm.v
// two-channel 16-bit timer and pulse-width unit with byte registers
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_defs.vh"

module two_channel_timer_pwm (
  input  wire       core_clk,      // 125 MHz bus clock
  input  wire       rst,           // async reset, active high
  input  wire [3:0] reg_addr,      // register index
  input  wire [7:0] reg_wdata,     // register write data
  input  wire       reg_wr,        // write strobe
  input  wire       reg_rd,        // read strobe
  output reg  [7:0] reg_rdata,     // read data, cycle after strobe
  input  wire       ext_clk_500k,  // crystal-derived clock pin
  input  wire       lfo_in,        // low_freq_oscillator output
  input  wire [1:0] chan_pin_in,   // porta_upper_pin_pair inputs
  input  wire [1:0] pins_claimed,  // pins taken by receiver or gpio
  output reg  [1:0] chan_pin_out,  // porta_upper_pin_pair outputs
  output reg  [1:0] chan_pin_oe_n, // low while the unit drives a pin
  output reg  [1:0] irq_ch,        // channel interrupt requests
  output reg        irq_ovf        // terminal count interrupt
);
  localparam ST_UP   = 2'b01;
  localparam ST_DOWN = 2'b10;

  // enable mask for a prescaler tap
  function [6:0] tap_mask;
    input [2:0] ps;
    begin
      tap_mask = 7'h7f >> (3'h7 - ps);
    end
  endfunction

  // terminal count of the counter
  function [15:0] top_of;
    input [15:0] m;
    begin
      if (m == `RST_WORD || m == `FREE_TOP)
        top_of = `FREE_TOP;
      else
        top_of = m;
    end
  endfunction

  reg        ovf_flag;
  reg        ovf_armed;
  reg        ovf_ie;
  reg        center_aligned_pulse_mode;
  reg [1:0]  clk_sel;
  reg [2:0]  ps;
  reg [15:0] cnt;
  reg [15:0] modv;
  reg [1:0]  route_en;
  reg        lfo_to_ch0;
  reg [6:0]  presc;
  reg [1:0]  dir_state;
  reg        cnt_upd;
  reg        boundary;

  reg        ext_s1;
  reg        ext_s2;
  reg        ext_s3;
  reg [1:0]  pin_s1;
  reg [1:0]  pin_s2;
  reg        lfo_s1;
  reg        lfo_s2;

  reg [15:0] next_cnt;
  reg [1:0]  next_dir;
  reg        ovf_evt;
  reg [7:0]  next_rdata;

  wire        src_en;
  wire        tick;
  wire [15:0] top;
  wire        wr_sc;
  wire        cnt_wr;
  wire [7:0]  sc_byte;
  wire [7:0]  ch_sc [0:1];
  wire [15:0] ch_val [0:1];
  wire [1:0]  ch_drive;
  wire [1:0]  ch_level;
  wire [1:0]  ch_irq;
  wire [1:0]  cap_src;
  wire [1:0]  ch_sc_wr = {reg_wr && reg_addr == `OFS_CH1_CTRL,
                          reg_wr && reg_addr == `OFS_CH0_CTRL};
  wire [1:0]  ch_sc_rd = {reg_rd && reg_addr == `OFS_CH1_CTRL,
                          reg_rd && reg_addr == `OFS_CH0_CTRL};
  wire [1:0]  ch_vh_wr = {reg_wr && reg_addr == `OFS_CH1_VAL_HIGH,
                          reg_wr && reg_addr == `OFS_CH0_VAL_HIGH};
  wire [1:0]  ch_vl_wr = {reg_wr && reg_addr == `OFS_CH1_VAL_LOW,
                          reg_wr && reg_addr == `OFS_CH0_VAL_LOW};

  // pins and the external clock cross in through two flops
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      pin_s1 <= 2'b11;
      pin_s2 <= 2'b11;
      lfo_s1 <= 1'b0;
      lfo_s2 <= 1'b0;
    end else begin
      ext_s1 <= ext_clk_500k;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      pin_s1 <= chan_pin_in;
      pin_s2 <= pin_s1;
      lfo_s1 <= lfo_in;
      lfo_s2 <= lfo_s1;
    end
  end

  // clock source choice and prescaler
  assign src_en = (clk_sel == `CLKSEL_BUS) |
                  ((clk_sel == `CLKSEL_XTAL) & ext_s2 & ~ext_s3);
  assign tick   = src_en & ((presc & tap_mask(ps)) == tap_mask(ps));
  assign top    = top_of(modv);
  assign wr_sc  = reg_wr & (reg_addr == `OFS_STATUS_CTRL);
  assign cnt_wr = reg_wr & ((reg_addr == `OFS_COUNT_HIGH) |
                            (reg_addr == `OFS_COUNT_LOW));
  assign sc_byte = {ovf_flag, ovf_ie, center_aligned_pulse_mode, clk_sel, ps};

  // channel 0 may watch the low-frequency oscillator instead of its pin
  assign cap_src = {pin_s2[1], lfo_to_ch0 ? lfo_s2 : pin_s2[0]};

  // counter next value: up to the top, or up and down in center mode
  always @* begin
    next_cnt = cnt;
    next_dir = dir_state;
    ovf_evt  = 1'b0;
    if (tick) begin
      if (center_aligned_pulse_mode) begin
        case (dir_state)
          ST_UP: begin
            if (cnt >= top) begin
              next_cnt = cnt - 16'h0001;
              next_dir = ST_DOWN;
              ovf_evt  = 1'b1;
            end else begin
              next_cnt = cnt + 16'h0001;
            end
          end
          ST_DOWN: begin
            if (cnt == `RST_WORD) begin
              next_cnt = cnt + 16'h0001;
              next_dir = ST_UP;
            end else begin
              next_cnt = cnt - 16'h0001;
            end
          end
          default: begin
            next_cnt = `RST_WORD;
            next_dir = ST_UP;
          end
        endcase
      end else begin
        next_dir = ST_UP;
        if (cnt >= top) begin
          next_cnt = `RST_WORD;
          ovf_evt  = 1'b1;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt       <= `RST_WORD;
      presc     <= 7'h00;
      dir_state <= ST_UP;
      cnt_upd   <= 1'b0;
      boundary  <= 1'b0;
    end else if (cnt_wr) begin
      cnt       <= `RST_WORD;
      presc     <= 7'h00;
      dir_state <= ST_UP;
      cnt_upd   <= 1'b0;
      boundary  <= 1'b0;
    end else begin
      if (src_en)
        presc <= presc + 7'h01;
      cnt       <= next_cnt;
      dir_state <= next_dir;
      cnt_upd   <= tick;
      boundary  <= ovf_evt;
    end
  end

  // status and control, overflow flag, modulus and pin options
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovf_flag   <= 1'b0;
      ovf_armed  <= 1'b0;
      ovf_ie     <= 1'b0;
      center_aligned_pulse_mode       <= 1'b0;
      clk_sel    <= `CLKSEL_NONE;
      ps         <= 3'h0;
      modv       <= `RST_WORD;
      route_en   <= 2'b00;
      lfo_to_ch0 <= 1'b0;
    end else begin
      if (ovf_evt & ~cnt_wr) begin
        ovf_flag  <= 1'b1;
        ovf_armed <= 1'b0;
      end else if (wr_sc & ovf_armed & ~reg_wdata[`SC_OVF_FLAG]) begin
        ovf_flag  <= 1'b0;
        ovf_armed <= 1'b0;
      end else if (reg_rd && reg_addr == `OFS_STATUS_CTRL && ovf_flag) begin
        ovf_armed <= 1'b1;
      end
      if (wr_sc) begin
        ovf_ie  <= reg_wdata[`SC_OVF_IE];
        center_aligned_pulse_mode    <= reg_wdata[`SC_CENTER_ALIGNED_PULSE_MODE];
        clk_sel <= reg_wdata[`SC_CLKSEL_HI:`SC_CLKSEL_LO];
        ps      <= reg_wdata[`SC_PS_HI:`SC_PS_LO];
      end
      if (reg_wr && reg_addr == `OFS_MODULUS_HIGH)
        modv[15:8] <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_MODULUS_LOW)
        modv[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_PIN_OPTION) begin
        route_en   <= reg_wdata[`OPT_ROUTE_HI:`OPT_ROUTE_LO];
        lfo_to_ch0 <= reg_wdata[`OPT_LFO_CH0];
      end
    end
  end

  // read data; reading the counter does not touch it
  always @* begin
    case (reg_addr)
      `OFS_STATUS_CTRL:  next_rdata = sc_byte;
      `OFS_COUNT_HIGH:   next_rdata = cnt[15:8];
      `OFS_COUNT_LOW:    next_rdata = cnt[7:0];
      `OFS_MODULUS_HIGH: next_rdata = modv[15:8];
      `OFS_MODULUS_LOW:  next_rdata = modv[7:0];
      `OFS_CH0_CTRL:     next_rdata = ch_sc[0];
      `OFS_CH0_VAL_HIGH: next_rdata = ch_val[0][15:8];
      `OFS_CH0_VAL_LOW:  next_rdata = ch_val[0][7:0];
      `OFS_CH1_CTRL:     next_rdata = ch_sc[1];
      `OFS_CH1_VAL_HIGH: next_rdata = ch_val[1][15:8];
      `OFS_CH1_VAL_LOW:  next_rdata = ch_val[1][7:0];
      `OFS_PIN_OPTION:   next_rdata = {5'h00, lfo_to_ch0, route_en};
      default:           next_rdata = `RST_BYTE;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst)
      reg_rdata <= `RST_BYTE;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= `RST_BYTE;
  end

  // two identical channels on the shared counter
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
      timer_channel u_ch (
        .core_clk   (core_clk),
        .rst        (rst),
        .cnt        (cnt),
        .cnt_upd    (cnt_upd),
        .boundary   (boundary),
        .center_aligned_pulse_mode       (center_aligned_pulse_mode),
        .count_down (dir_state == ST_DOWN),
        .cnt_run    (clk_sel != `CLKSEL_NONE),
        .cap_in     (cap_src[gi]),
        .sc_wr      (ch_sc_wr[gi]),
        .sc_rd      (ch_sc_rd[gi]),
        .vh_wr      (ch_vh_wr[gi]),
        .vl_wr      (ch_vl_wr[gi]),
        .wdata      (reg_wdata),
        .sc         (ch_sc[gi]),
        .value      (ch_val[gi]),
        .pin_drive  (ch_drive[gi]),
        .pin_level  (ch_level[gi]),
        .irq_req    (ch_irq[gi])
      );
    end
  endgenerate

  // pin ownership and interrupt outputs
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chan_pin_out  <= 2'b00;
      chan_pin_oe_n <= 2'b11;
      irq_ch        <= 2'b00;
      irq_ovf       <= 1'b0;
    end else begin
      chan_pin_out  <= ch_level;
      chan_pin_oe_n <= ~(ch_drive & route_en & ~pins_claimed);
      irq_ch        <= ch_irq;
      irq_ovf       <= ovf_flag & ovf_ie;
    end
  end
endmodule
`default_nettype wire

// ===== common/timer_pwm_defs.vh
// register offsets, field positions, reset values and codes of the timer
`ifndef TIMER_PWM_DEFS_VH
`define TIMER_PWM_DEFS_VH

// register indices on the byte register port
`define OFS_STATUS_CTRL  4'h0
`define OFS_COUNT_HIGH   4'h1
`define OFS_COUNT_LOW    4'h2
`define OFS_MODULUS_HIGH 4'h3
`define OFS_MODULUS_LOW  4'h4
`define OFS_CH0_CTRL     4'h5
`define OFS_CH0_VAL_HIGH 4'h6
`define OFS_CH0_VAL_LOW  4'h7
`define OFS_CH1_CTRL     4'h8
`define OFS_CH1_VAL_HIGH 4'h9
`define OFS_CH1_VAL_LOW  4'ha
`define OFS_PIN_OPTION   4'hb

// status and control fields
`define SC_OVF_FLAG   7
`define SC_OVF_IE     6
`define SC_CENTER_ALIGNED_PULSE_MODE       5
`define SC_CLKSEL_HI  4
`define SC_CLKSEL_LO  3
`define SC_PS_HI      2
`define SC_PS_LO      0

// channel control fields
`define CH_FLAG   7
`define CH_IE     6
`define CH_MS_B   5
`define CH_MS_A   4
`define CH_ELS_B  3
`define CH_ELS_A  2

// pin option fields
`define OPT_ROUTE_HI  1
`define OPT_ROUTE_LO  0
`define OPT_LFO_CH0   2

// clock select codes
`define CLKSEL_NONE   2'h0
`define CLKSEL_BUS    2'h1
`define CLKSEL_UNUSED 2'h2
`define CLKSEL_XTAL   2'h3

// reset values, free-running top and external clock rate
`define RST_BYTE   8'h00
`define RST_WORD   16'h0000
`define FREE_TOP   16'hffff
`define EXT_CLK_KHZ 500

`endif

// ===== src/timer_channel.v
// one timer channel: capture, compare and buffered pulse-width output
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_defs.vh"

module timer_channel (
  input  wire        core_clk,    // bus clock
  input  wire        rst,         // async reset, active high
  input  wire [15:0] cnt,         // shared counter
  input  wire        cnt_upd,     // counter just changed
  input  wire        boundary,    // period boundary pulse
  input  wire        center_aligned_pulse_mode,        // center-aligned mode
  input  wire        count_down,  // counter going down
  input  wire        cnt_run,     // clock select is not the none code
  input  wire        cap_in,      // synchronised capture input
  input  wire        sc_wr,       // control write
  input  wire        sc_rd,       // control read
  input  wire        vh_wr,       // value high byte write
  input  wire        vl_wr,       // value low byte write
  input  wire [7:0]  wdata,       // write data
  output wire [7:0]  sc,          // control read value
  output wire [15:0] value,       // active channel value
  output wire        pin_drive,   // channel wants the pin
  output wire        pin_level,   // channel output level
  output wire        irq_req      // flag and enable
);
  reg        flag;
  reg        armed;
  reg        ie;
  reg        ms_b;
  reg        ms_a;
  reg        els_b;
  reg        els_a;
  reg        in_d;
  reg        out_lvl;
  reg [15:0] val;
  reg [15:0] pend;

  wire pwm_mode = center_aligned_pulse_mode | ms_b;
  wire cap_mode = ~center_aligned_pulse_mode & ~ms_b & ~ms_a;
  wire cmp_mode = ~center_aligned_pulse_mode & ~ms_b & ms_a;
  wire rise     = cap_in & ~in_d;
  wire fall     = ~cap_in & in_d;
  wire cap_evt  = cap_mode & cnt_run &
                  ((els_a & rise) | (els_b & fall));
  wire match    = cnt_upd & ~cap_mode & (cnt == val);
  wire act      = ~els_a;

  assign sc        = {flag, ie, ms_b, ms_a, els_b, els_a, 2'b00};
  assign value     = val;
  assign pin_drive = (cmp_mode | pwm_mode) & (els_b | els_a);
  assign pin_level = out_lvl;
  assign irq_req   = flag & ie;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag  <= 1'b0;
      armed <= 1'b0;
      ie    <= 1'b0;
      ms_b  <= 1'b0;
      ms_a  <= 1'b0;
      els_b <= 1'b0;
      els_a <= 1'b0;
    end else begin
      if (cap_evt | match) begin
        flag  <= 1'b1;
        armed <= 1'b0;
      end else if (sc_wr & armed & ~wdata[`CH_FLAG]) begin
        flag  <= 1'b0;
        armed <= 1'b0;
      end else if (sc_rd & flag) begin
        armed <= 1'b1;
      end
      if (sc_wr) begin
        ie    <= wdata[`CH_IE];
        ms_b  <= wdata[`CH_MS_B];
        ms_a  <= wdata[`CH_MS_A];
        els_b <= wdata[`CH_ELS_B];
        els_a <= wdata[`CH_ELS_A];
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      val  <= `RST_WORD;
      pend <= `RST_WORD;
      in_d <= 1'b1;
    end else begin
      in_d <= cap_in;
      if (vh_wr)
        pend[15:8] <= wdata;
      if (vl_wr)
        pend[7:0] <= wdata;
      if (cap_evt) begin
        val <= cnt;
      end else if (pwm_mode) begin
        if (boundary)
          val <= pend;
      end else begin
        if (vh_wr)
          val[15:8] <= wdata;
        if (vl_wr)
          val[7:0] <= wdata;
      end
    end
  end

  // output action for compare, edge and center pulse modes
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_lvl <= 1'b0;
    end else if (center_aligned_pulse_mode) begin
      if (match)
        out_lvl <= count_down ? act : ~act;
    end else if (ms_b) begin
      if (match)
        out_lvl <= ~act;
      else if (cnt_upd && cnt == `RST_WORD)
        out_lvl <= act;
    end else if (cmp_mode & match) begin
      case ({els_b, els_a})
        2'b01:   out_lvl <= ~out_lvl;
        2'b10:   out_lvl <= 1'b0;
        2'b11:   out_lvl <= 1'b1;
        default: out_lvl <= out_lvl;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verif/timer_pwm_properties.sv
// port properties of the two-channel timer and pulse-width unit
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_properties (
  input wire logic       core_clk,      // bus clock
  input wire logic       rst,           // async reset
  input wire logic [3:0] reg_addr,      // register index
  input wire logic [7:0] reg_wdata,     // write data
  input wire logic       reg_wr,        // write strobe
  input wire logic [1:0] pins_claimed,  // pins taken elsewhere
  input wire logic [1:0] chan_pin_oe_n, // low while driven
  input wire logic [1:0] irq_ch,        // channel requests
  input wire logic       irq_ovf        // terminal count request
);
  logic [1:0] claim_d1;
  logic       started;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // claim history and whether a nonzero clock select was ever written
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      claim_d1 <= 2'b00;
      started  <= 1'b0;
    end else begin
      claim_d1 <= pins_claimed;
      if (reg_wr && reg_addr == 4'h0 && reg_wdata[4:3] != 2'b00)
        started <= 1'b1;
    end
  end
  sequence s_wr(logic [3:0] a);
    reg_wr && reg_addr == a;
  endsequence
  property p_reset_idle;
    $fell(rst) |-> chan_pin_oe_n == 2'b11 && irq_ch == 2'b00 && !irq_ovf;
  endproperty
  property p_stopped_no_ovf;
    !started |-> !irq_ovf;
  endproperty
  property p_ovf_ie_off;
    s_wr(4'h0) ##0 !reg_wdata[6] |=> ##1 !irq_ovf;
  endproperty
  property p_ch0_ie_off;
    s_wr(4'h5) ##0 !reg_wdata[6] |=> ##1 !irq_ch[0];
  endproperty
  property p_ch1_ie_off;
    s_wr(4'h8) ##0 !reg_wdata[6] |=> ##1 !irq_ch[1];
  endproperty
  property p_capture_idle;
    s_wr(4'h5) ##0 reg_wdata[5:4] == 2'b00 |=> ##1 chan_pin_oe_n[0];
  endproperty
  property p_route_off;
    s_wr(4'hb) ##0 reg_wdata[1:0] == 2'b00 |=> ##1 chan_pin_oe_n == 2'b11;
  endproperty
  property p_claimed;
    (claim_d1 & ~chan_pin_oe_n) == 2'b00;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  a_stopped_no_ovf: assert property (p_stopped_no_ovf)
    else $error("overflow request without a clock source");
  a_ovf_ie_off: assert property (p_ovf_ie_off)
    else $error("overflow request with enable off");
  a_ch0_ie_off: assert property (p_ch0_ie_off)
    else $error("channel 0 request with enable off");
  a_ch1_ie_off: assert property (p_ch1_ie_off)
    else $error("channel 1 request with enable off");
  a_capture_idle: assert property (p_capture_idle)
    else $error("capture channel drives its pin");
  a_route_off: assert property (p_route_off)
    else $error("unrouted pin still driven");
  a_claimed: assert property (p_claimed)
    else $error("claimed pin driven");
endmodule
bind two_channel_timer_pwm timer_pwm_properties props (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .pins_claimed(pins_claimed),
  .chan_pin_oe_n(chan_pin_oe_n), .irq_ch(irq_ch), .irq_ovf(irq_ovf)
);
`default_nettype wire

// ===== verif/pin_side_model.sv
// pin side: pulled-up pins, crystal-derived clock, slow oscillator
`timescale 1ns/1ps
`default_nettype none
module pin_side_model #(
  parameter int LFO_HALF_NS = 2000  // shortened oscillator half period
) (
  input  wire logic [1:0] pin_out,  // unit pin levels
  input  wire logic [1:0] pin_oe_n, // low while unit drives
  input  wire logic [1:0] stim,     // outside driver, 1 = released
  output logic      [1:0] pin_in,   // resolved pin levels
  output logic            xtal_clk, // 500 kHz clock
  output logic            low_freq_oscillator       // slow oscillator
);
  // pull-up pins: the unit's level wins where it drives
  always_comb pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & stim);
  initial begin
    xtal_clk = 1'b0;
    #137;
    forever #1000 xtal_clk = ~xtal_clk;
  end
  initial begin
    low_freq_oscillator = 1'b0;
    forever #LFO_HALF_NS low_freq_oscillator = ~low_freq_oscillator;
  end
endmodule
`default_nettype wire

// ===== verif/test_two_channel_timer_pwm.sv
// self-checking bench for the two-channel timer and pulse-width unit
`timescale 1ns/1ps
`default_nettype none
module test_two_channel_timer_pwm;
  logic       core_clk, rst, reg_wr, reg_rd, irq_ovf, xclk, low_freq_oscillator;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, e;
  logic [1:0] pins_claimed, stim, pin_in, pin_out, oe_n, irq_ch;
  int         n_mismatch, n_tests, i, k, c;

  two_channel_timer_pwm dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_clk_500k(xclk), .lfo_in(low_freq_oscillator),
    .chan_pin_in(pin_in), .pins_claimed(pins_claimed),
    .chan_pin_out(pin_out), .chan_pin_oe_n(oe_n), .irq_ch(irq_ch),
    .irq_ovf(irq_ovf));
  pin_side_model partner (
    .pin_out(pin_out), .pin_oe_n(oe_n), .stim(stim), .pin_in(pin_in),
    .xtal_clk(xclk), .low_freq_oscillator(low_freq_oscillator));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] x, g);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic rng(input string nm, input int v, lo, hi);
    chk(nm, 16'h0001, 16'(v >= lo && v <= hi));
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic rck(input logic [3:0] a, input logic [7:0] x,
                     input string nm);
    logic [7:0] v;
    rd(a, v);
    chk(nm, {8'h00, x}, {8'h00, v});
  endtask
  task automatic hi_cnt(input int ch, n, output int cnt);
    cnt = 0;
    repeat (n) begin
      tick();
      cnt += int'(pin_out[ch] === 1'b1);
    end
  endtask

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    pins_claimed = 2'b00;
    stim = 2'b11;
    n_mismatch = 0;
    n_tests = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (i = 0; i < 16; i++) rck(4'(i), 8'h00, "reset value");
    wr(4'hc, 8'hff);
    rck(4'hc, 8'h00, "unmapped");
    wr(4'h5, 8'hfc);
    rck(4'h5, 8'h7c, "channel control");
    wr(4'hb, 8'hff);
    rck(4'hb, 8'h07, "pin option");
    wr(4'h5, 8'h00);
    wr(4'hb, 8'h00);
    wr(4'h0, 8'h08);
    rd(4'h2, d);
    rd(4'h2, e);
    chk("live count step", 16'h0002, 16'(8'(e - d)));
    repeat (20) @(posedge core_clk);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h55);
    rck(4'h1, 8'h00, "count high");
    rck(4'h2, 8'h00, "count low");
    for (i = 0; i < 8; i++) begin
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h08 | 8'(i));
      repeat (10 << i) @(posedge core_clk);
      wr(4'h0, 8'h00);
      rd(4'h2, d);
      rng("prescaled count", d, 9, 12);
    end
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h18);
    repeat (2500) @(posedge core_clk);
    wr(4'h0, 8'h00);
    rd(4'h2, d);
    rng("external count", d, 9, 11);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h10);
    repeat (100) @(posedge core_clk);
    rck(4'h2, 8'h00, "unused select count");
    wr(4'h1, 8'h00);
    wr(4'h4, 8'h10);
    wr(4'h0, 8'h48);
    for (k = 0; k < 100 && irq_ovf !== 1'b1; k++) tick();
    if (k == 100) begin
      n_mismatch++;
      $display("Error overflow wait expected 1 seen 0");
      finish_test();
    end
    rng("overflow delay", k, 16, 21);
    wr(4'h0, 8'h40);
    rck(4'h0, 8'hc0, "overflow flag set");
    wr(4'h0, 8'h40);
    rck(4'h0, 8'h40, "overflow flag cleared");
    chk("overflow request", 16'h0000, {15'h0000, irq_ovf});
    wr(4'h0, 8'h48);
    repeat (20) @(posedge core_clk);
    rd(4'h0, d);
    repeat (20) @(posedge core_clk);
    wr(4'h0, 8'h40);
    rck(4'h0, 8'hc0, "flag after late overflow");
    wr(4'h4, 8'h09);
    wr(4'h1, 8'h00);
    wr(4'h7, 8'h05);
    wr(4'hb, 8'h01);
    wr(4'h5, 8'h1c);
    wr(4'h0, 8'h08);
    repeat (30) tick();
    chk("compare set", 16'h0001, {15'h0000, pin_out[0]});
    chk("pin driven", 16'h0000, {15'h0000, oe_n[0]});
    wr(4'h5, 8'h18);
    repeat (30) tick();
    chk("compare clear", 16'h0000, {15'h0000, pin_out[0]});
    wr(4'h5, 8'h14);
    repeat (30) tick();
    d[0] = pin_out[0];
    repeat (10) tick();
    chk("toggle", {15'h0000, ~d[0]}, {15'h0000, pin_out[0]});
    rck(4'h5, 8'h94, "compare flag");
    pins_claimed <= 2'b01;
    repeat (4) tick();
    chk("claimed pin", 16'h0001, {15'h0000, oe_n[0]});
    pins_claimed <= 2'b00;
    wr(4'hb, 8'h00);
    wr(4'h4, 8'h00);
    // a zero match value cannot hit before the free-running wrap
    wr(4'h7, 8'h00);
    repeat (4) tick();
    for (i = 1; i < 4; i++) begin
      rd(4'h5, d);
      wr(4'h5, 8'h40 | 8'(i << 2));
      stim[0] <= 1'b0;
      repeat (8) tick();
      chk("capture on fall", 16'(i >> 1), {15'h0000, irq_ch[0]});
      rd(4'h5, d);
      wr(4'h5, 8'h40 | 8'(i << 2));
      stim[0] <= 1'b1;
      repeat (8) tick();
      chk("capture on rise", 16'(i & 1), {15'h0000, irq_ch[0]});
    end
    rd(4'h7, d);
    rd(4'h2, e);
    rng("capture value", 8'(e - d), 4, 30);
    wr(4'hb, 8'h04);
    rd(4'h5, d);
    wr(4'h5, 8'h44);
    repeat (520) tick();
    chk("oscillator capture", 16'h0001, {15'h0000, irq_ch[0]});
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h09);
    wr(4'h1, 8'h00);
    wr(4'ha, 8'h03);
    wr(4'hb, 8'h02);
    wr(4'h8, 8'h28);
    wr(4'h0, 8'h08);
    repeat (20) tick();
    hi_cnt(1, 100, c);
    chk("high-true pulse", 16'h001e, 16'(c));
    chk("pin 1 driven", 16'h0000, {15'h0000, oe_n[1]});
    wr(4'h8, 8'h24);
    repeat (20) tick();
    hi_cnt(1, 100, c);
    chk("low-true pulse", 16'h0046, 16'(c));
    // with the counter stopped no boundary comes, so the old duty stays
    wr(4'h0, 8'h00);
    wr(4'ha, 8'h06);
    rck(4'ha, 8'h03, "duty held");
    wr(4'h0, 8'h08);
    repeat (20) tick();
    hi_cnt(1, 100, c);
    chk("buffered duty", 16'h0028, 16'(c));
    wr(4'h8, 8'h28);
    wr(4'h0, 8'h28);
    repeat (40) tick();
    hi_cnt(1, 180, c);
    chk("center pulse", 16'h0078, 16'(c));
    finish_test();
  end
endmodule
`default_nettype wire
